/* hw/omx_params.svh */
// Offsets, field positions, reset values and constants of the OSD palette and alpha mixer
//
// How it works
// R1: LUT word is R, G, B, factor
// R2: Factors above 80h act as 80h
// R3: Factor 0 transparent, 80h fully opaque
// R4: Palette copied into LUT before display
// R5: Words copied equal count field plus one
// R6: At most 256 colours per load
// R7: Palette read from consecutive words at pointer
// R8: Load start offsets writes, never display reads
// R9: New palette needs flag, pointer, count, start
// R10: Pixels left to right, top field first
// R11: Pixel byte is the LUT index
// R12: Software gives equal top and bottom pixel counts
// R13: Field blocks contiguous and word aligned
// R14: Own field pointers, or bottom merged after top
// R15: Every OSD pixel blended with video pixel
// R16: Two-bit mode selects one of four blends
// R17: Per-pixel mode uses LUT factor only
// R18: Region-global mode uses clamped region weight
// R19: Proportional mode multiplies or divides by gain
// R20: No-mixing mode shows OSD fully opaque
// R21: Flag zero keeps LUT, one loads palette
// R22: Region weight above 80h acts as 80h
// R23: Four pixels per word, leftmost lowest byte
// R24: Blend weighted sum over 128, saturated factor
`ifndef OMX_PARAMS_SVH
`define OMX_PARAMS_SVH

`define OMX_OFS_CTRL      8'h00
`define OMX_OFS_PAL_PTR   8'h04
`define OMX_OFS_LOAD      8'h08
`define OMX_OFS_MIX       8'h0C
`define OMX_OFS_TOP_PTR   8'h10
`define OMX_OFS_BOT_PTR   8'h14
`define OMX_OFS_FIELD_PIX 8'h18
`define OMX_OFS_STATUS    8'h1C

`define OMX_CTRL_START    0
`define OMX_CTRL_FRESH    1
`define OMX_CTRL_MODE_LO  2
`define OMX_CTRL_MODE_HI  3
`define OMX_CTRL_MERGE    4
`define OMX_LOAD_CNT_LO   0
`define OMX_LOAD_CNT_HI   7
`define OMX_LOAD_ST_LO    8
`define OMX_LOAD_ST_HI    15
`define OMX_MIX_W_LO      0
`define OMX_MIX_W_HI      7
`define OMX_MIX_G_LO      16
`define OMX_MIX_G_HI      24
`define OMX_STAT_BUSY     0
`define OMX_STAT_LOAD     1
`define OMX_STAT_SHOW     2
`define OMX_STAT_DONE     3
`define OMX_STAT_BOTTOM   4

`define OMX_RST_WEIGHT    8'h80
`define OMX_RST_GAIN      9'h080
`define OMX_ALPHA_FULL    8'h80
`define OMX_WORD_BYTES    32'h0000_0004

`endif

/* hw/omx_pkg.sv */
// Types of the OSD palette and alpha mixer
`default_nettype none
package omx_pkg;

   typedef enum logic [3:0] {
      ST_IDLE      = 4'h1,
      ST_LOAD_REQ  = 4'h2,
      ST_LOAD_WAIT = 4'h4,
      ST_SHOW      = 4'h8
   } omx_state_e;

   typedef enum logic [1:0] {
      MODE_PIXEL  = 2'h0,
      MODE_GLOBAL = 2'h1,
      MODE_PROP   = 2'h2,
      MODE_NONE   = 2'h3
   } omx_mode_e;

   typedef struct packed {
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
   } omx_rgb_s;

   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
   } omx_mem_req_s;

   typedef struct packed {
      logic        valid;
      logic [31:0] data;
   } omx_mem_rsp_s;

   typedef struct packed {
      omx_state_e  state;
      logic        fresh;
      omx_mode_e   mode;
      logic        merged;
      logic [31:0] pal_ptr;
      logic [7:0]  load_cnt;
      logic [7:0]  load_start;
      logic [7:0]  weight;
      logic [8:0]  gain;
      logic [31:0] top_ptr;
      logic [31:0] bot_ptr;
      logic [21:0] field_pix;
      logic        done;
      logic [8:0]  load_idx;
      logic [31:0] addr;
      logic        req_out;
      logic [21:0] pix_left;
      logic        field_bot;
      logic [31:0] word;
      logic [1:0]  byte_idx;
      logic        wb_v;
      omx_rgb_s    out_pix;
      logic        out_valid;
   } omx_core_s;

endpackage
`default_nettype wire

/* hw/omx_mixer.sv */
// OSD palette loader, bitmap fetcher and OSD/video blender with APB registers
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "omx_params.svh"

module omx_mixer (
   input  wire logic                 core_clk,
   input  wire logic                 srst,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   output omx_pkg::omx_mem_req_s     mem_req,
   input  wire logic                 mem_req_ready,
   input  wire omx_pkg::omx_mem_rsp_s mem_rsp,
   input  wire logic                 vid_in_valid,
   input  wire omx_pkg::omx_rgb_s    vid_in_pix,
   output logic                      vid_in_ready,
   output logic                      vid_out_valid,
   output omx_pkg::omx_rgb_s         vid_out_pix
);

   omx_pkg::omx_core_s q;
   omx_pkg::omx_core_s d;

   logic [31:0]       lut_mem [0:255];
   logic              lut_we;
   logic [7:0]        lut_wa;
   logic [7:0]        px_idx;
   logic [31:0]       ent;
   omx_pkg::omx_rgb_s ent_rgb;
   logic [7:0]        alpha_c;
   logic [15:0]       prop_mul;
   logic [15:0]       prop_div;
   logic [7:0]        factor;
   omx_pkg::omx_rgb_s mixed;
   logic              consume;
   logic              wr_acc;
   logic              hit;
   logic              start_ok;

   // Anything above full opacity acts as full opacity
   function automatic logic [7:0] clamp80(input logic [15:0] v);
      return (v > {8'h00, `OMX_ALPHA_FULL}) ? `OMX_ALPHA_FULL : v[7:0];
   endfunction

   // Weighted sum over 128; factor never exceeds 80h here
   function automatic logic [7:0] mix_ch(input logic [7:0] osd, input logic [7:0] vid, input logic [7:0] f);
      logic [15:0] acc;
      acc = ({8'h00, osd} * {8'h00, f}) + ({8'h00, vid} * {8'h00, `OMX_ALPHA_FULL - f});
      return acc[14:7];
   endfunction

   function automatic logic is_reg(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= `OMX_OFS_STATUS);
   endfunction

   // Display reads index the table by pixel value only
   assign px_idx  = q.word[{q.byte_idx, 3'h0} +: 8]; // R11 R23 R8
   assign ent     = lut_mem[px_idx];
   assign ent_rgb = ent[31:8]; // R1
   assign alpha_c = clamp80({8'h00, ent[7:0]}); // R2

   assign prop_mul = {8'h00, alpha_c} * {8'h00, q.gain[7:0]};
   // Divide by zero gain saturates instead of wrapping
   assign prop_div = (q.gain[7:0] == 8'h00) ? 16'hFFFF
                   : ({1'b0, alpha_c, 7'h00} / {8'h00, q.gain[7:0]});

   always_comb begin
      case (q.mode) // R16
         omx_pkg::MODE_PIXEL:  factor = alpha_c; // R17
         omx_pkg::MODE_GLOBAL: factor = clamp80({8'h00, q.weight}); // R18 R22
         omx_pkg::MODE_PROP:   factor = clamp80(q.gain[8] ? prop_mul : prop_div); // R19 R24
         omx_pkg::MODE_NONE:   factor = `OMX_ALPHA_FULL; // R20
         default:              factor = alpha_c;
      endcase
   end

   // Factor 0 yields video, 80h yields OSD colour
   assign mixed.r = mix_ch(ent_rgb.r, vid_in_pix.r, factor); // R3 R15 R24
   assign mixed.g = mix_ch(ent_rgb.g, vid_in_pix.g, factor); // R3 R15 R24
   assign mixed.b = mix_ch(ent_rgb.b, vid_in_pix.b, factor); // R3 R15 R24

   // Video stalls only while a bitmap word is awaited
   assign vid_in_ready = (q.state != omx_pkg::ST_SHOW) || q.wb_v;
   assign consume      = vid_in_valid && vid_in_ready;

   assign hit      = is_reg(paddr);
   assign wr_acc   = psel && penable && pwrite && hit;
   assign start_ok = wr_acc && (paddr == `OMX_OFS_CTRL) && pwdata[`OMX_CTRL_START]
                     && (q.state == omx_pkg::ST_IDLE);
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !hit;

   always_comb begin
      prdata = 32'h0000_0000;
      if (psel && !pwrite) begin
         case (paddr)
            `OMX_OFS_CTRL: begin
               prdata[`OMX_CTRL_FRESH] = q.fresh;
               prdata[`OMX_CTRL_MODE_HI:`OMX_CTRL_MODE_LO] = q.mode;
               prdata[`OMX_CTRL_MERGE] = q.merged;
            end
            `OMX_OFS_PAL_PTR: prdata = q.pal_ptr;
            `OMX_OFS_LOAD: begin
               prdata[`OMX_LOAD_CNT_HI:`OMX_LOAD_CNT_LO] = q.load_cnt;
               prdata[`OMX_LOAD_ST_HI:`OMX_LOAD_ST_LO]   = q.load_start;
            end
            `OMX_OFS_MIX: begin
               prdata[`OMX_MIX_W_HI:`OMX_MIX_W_LO] = q.weight;
               prdata[`OMX_MIX_G_HI:`OMX_MIX_G_LO] = q.gain;
            end
            `OMX_OFS_TOP_PTR:   prdata = q.top_ptr;
            `OMX_OFS_BOT_PTR:   prdata = q.bot_ptr;
            `OMX_OFS_FIELD_PIX: prdata[21:0] = q.field_pix;
            `OMX_OFS_STATUS: begin
               prdata[`OMX_STAT_BUSY]   = (q.state != omx_pkg::ST_IDLE);
               prdata[`OMX_STAT_LOAD]   = (q.state == omx_pkg::ST_LOAD_REQ) || (q.state == omx_pkg::ST_LOAD_WAIT);
               prdata[`OMX_STAT_SHOW]   = (q.state == omx_pkg::ST_SHOW);
               prdata[`OMX_STAT_DONE]   = q.done;
               prdata[`OMX_STAT_BOTTOM] = q.field_bot;
            end
            default: prdata = 32'h0000_0000;
         endcase
      end
   end

   always_comb begin
      mem_req.valid = 1'b0;
      mem_req.addr  = q.addr;
      case (q.state)
         omx_pkg::ST_LOAD_REQ: begin
            mem_req.valid = 1'b1;
            mem_req.addr  = q.pal_ptr + {21'h0, q.load_idx, 2'h0}; // R7
         end
         omx_pkg::ST_SHOW: mem_req.valid = !q.wb_v && !q.req_out && (q.pix_left != 22'h0);
         default: mem_req.valid = 1'b0;
      endcase
   end

   assign lut_we = (q.state == omx_pkg::ST_LOAD_WAIT) && mem_rsp.valid;
   assign lut_wa = q.load_start + q.load_idx[7:0]; // R8

   always_comb begin
      d = q;
      d.out_valid = 1'b0;
      if (wr_acc) begin
         case (paddr)
            `OMX_OFS_CTRL: begin
               d.fresh  = pwdata[`OMX_CTRL_FRESH]; // R9
               d.mode   = omx_pkg::omx_mode_e'(pwdata[`OMX_CTRL_MODE_HI:`OMX_CTRL_MODE_LO]);
               d.merged = pwdata[`OMX_CTRL_MERGE];
            end
            `OMX_OFS_PAL_PTR: d.pal_ptr = pwdata;
            `OMX_OFS_LOAD: begin
               d.load_cnt   = pwdata[`OMX_LOAD_CNT_HI:`OMX_LOAD_CNT_LO];
               d.load_start = pwdata[`OMX_LOAD_ST_HI:`OMX_LOAD_ST_LO];
            end
            `OMX_OFS_MIX: begin
               d.weight = pwdata[`OMX_MIX_W_HI:`OMX_MIX_W_LO];
               d.gain   = pwdata[`OMX_MIX_G_HI:`OMX_MIX_G_LO];
            end
            `OMX_OFS_TOP_PTR:   d.top_ptr = pwdata;
            `OMX_OFS_BOT_PTR:   d.bot_ptr = pwdata;
            `OMX_OFS_FIELD_PIX: d.field_pix = pwdata[21:0];
            `OMX_OFS_STATUS: begin
               if (pwdata[`OMX_STAT_DONE]) begin
                  d.done = 1'b0;
               end
            end
            default: d.done = q.done;
         endcase
      end

      if (consume) begin
         d.out_valid = 1'b1;
         d.out_pix   = (q.state == omx_pkg::ST_SHOW) ? mixed : vid_in_pix;
      end

      case (q.state)
         omx_pkg::ST_IDLE: begin
            if (start_ok) begin
               d.load_idx = 9'h000;
               // Without a fresh palette the table keeps its contents
               d.state = pwdata[`OMX_CTRL_FRESH] ? omx_pkg::ST_LOAD_REQ : omx_pkg::ST_SHOW; // R4 R21
               d.addr      = q.top_ptr; // R14
               d.pix_left  = q.field_pix;
               d.field_bot = 1'b0; // R10
               d.wb_v      = 1'b0;
               d.req_out   = 1'b0;
            end
         end
         omx_pkg::ST_LOAD_REQ: begin
            if (mem_req_ready) begin
               d.state = omx_pkg::ST_LOAD_WAIT;
            end
         end
         omx_pkg::ST_LOAD_WAIT: begin
            if (mem_rsp.valid) begin
               // Nine-bit index stops at 256 words at most
               if (q.load_idx == {1'b0, q.load_cnt}) begin // R5 R6
                  d.state = omx_pkg::ST_SHOW; // R4
               end else begin
                  d.load_idx = q.load_idx + 9'h001;
                  d.state    = omx_pkg::ST_LOAD_REQ;
               end
            end
         end
         omx_pkg::ST_SHOW: begin
            if (q.pix_left == 22'h0) begin
               d.state = omx_pkg::ST_IDLE;
               d.done  = 1'b1;
            end
            if (mem_req.valid && mem_req_ready) begin
               d.req_out = 1'b1;
               d.addr    = q.addr + `OMX_WORD_BYTES;
            end
            if (q.req_out && mem_rsp.valid) begin
               d.word     = mem_rsp.data;
               d.wb_v     = 1'b1;
               d.byte_idx = 2'h0;
               d.req_out  = 1'b0;
            end
            if (consume) begin
               d.byte_idx = q.byte_idx + 2'h1; // R23
               d.pix_left = q.pix_left - 22'h1;
               if ((q.byte_idx == 2'h3) || (q.pix_left == 22'h1)) begin
                  d.wb_v = 1'b0;
               end
               if (q.pix_left == 22'h1) begin
                  if (!q.field_bot) begin
                     // Merged layout continues at the next word after the top block
                     d.field_bot = 1'b1; // R10
                     d.pix_left  = q.field_pix; // R12
                     d.addr      = q.merged ? q.addr : q.bot_ptr; // R14 R13
                  end else begin
                     d.state = omx_pkg::ST_IDLE;
                     d.done  = 1'b1;
                  end
               end
            end
         end
         default: d.state = omx_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         q <= '{state: omx_pkg::ST_IDLE, mode: omx_pkg::MODE_PIXEL, weight: `OMX_RST_WEIGHT,
                gain: `OMX_RST_GAIN, out_pix: '0, default: '0};
      end else begin
         q <= d;
      end
   end

   // Table is plain storage; contents survive reset by intent
   always_ff @(posedge core_clk) begin
      if (lut_we) begin
         lut_mem[lut_wa] <= mem_rsp.data; // R1 R7
      end
   end

   assign vid_out_valid = q.out_valid;
   assign vid_out_pix   = q.out_pix;

   // Checks
   // Own write count, kept apart from the loader index
   logic [8:0] chk_writes_q;
   always_ff @(posedge core_clk) begin
      if (srst || start_ok) begin
         chk_writes_q <= 9'h000;
      end else if (lut_we) begin
         chk_writes_q <= chk_writes_q + 9'h001;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   property p_alpha_clamp;
      consume && (q.state == omx_pkg::ST_SHOW) && (q.mode == omx_pkg::MODE_PIXEL) && (ent[7:0] > 8'h80)
         |-> factor == 8'h80;
   endproperty
   a_alpha_clamp: assert property (p_alpha_clamp) else $error("alpha not clamped"); // R2

   property p_transparent;
      consume && (q.state == omx_pkg::ST_SHOW) && (factor == 8'h00) |=> vid_out_pix == $past(vid_in_pix);
   endproperty
   a_transparent: assert property (p_transparent) else $error("zero factor not transparent"); // R3

   property p_opaque;
      consume && (q.state == omx_pkg::ST_SHOW) && (q.mode == omx_pkg::MODE_NONE)
         |=> vid_out_valid && (vid_out_pix == $past(ent_rgb));
   endproperty
   a_opaque: assert property (p_opaque) else $error("no-mix pixel not opaque"); // R20

   property p_load_count;
      (q.state == omx_pkg::ST_LOAD_WAIT) && mem_rsp.valid && (q.load_idx == {1'b0, q.load_cnt})
         |=> (q.state == omx_pkg::ST_SHOW) && (chk_writes_q == $past(q.load_idx) + 9'h001);
   endproperty
   a_load_count: assert property (p_load_count) else $error("wrong palette word count"); // R5

   property p_lut_addr;
      lut_we |-> lut_wa == q.load_start + chk_writes_q[7:0];
   endproperty
   a_lut_addr: assert property (p_lut_addr) else $error("lut write address wrong"); // R8

   property p_pal_addr;
      mem_req.valid && (q.state == omx_pkg::ST_LOAD_REQ)
         |-> mem_req.addr == q.pal_ptr + {21'h0, chk_writes_q, 2'h0};
   endproperty
   a_pal_addr: assert property (p_pal_addr) else $error("palette address wrong"); // R7

   property p_keep_lut;
      start_ok && !pwdata[`OMX_CTRL_FRESH] |=> (q.state == omx_pkg::ST_SHOW) && !lut_we;
   endproperty
   a_keep_lut: assert property (p_keep_lut) else $error("palette loaded without flag"); // R21

   property p_global;
      consume && (q.state == omx_pkg::ST_SHOW) && (q.mode == omx_pkg::MODE_GLOBAL)
         |-> factor == ((q.weight > 8'h80) ? 8'h80 : q.weight);
   endproperty
   a_global: assert property (p_global) else $error("global weight misapplied"); // R18

   property p_bottom_ptr;
      consume && (q.state == omx_pkg::ST_SHOW) && !q.field_bot && (q.pix_left == 22'h1) && !q.merged
         |=> q.field_bot && (q.addr == $past(q.bot_ptr));
   endproperty
   a_bottom_ptr: assert property (p_bottom_ptr) else $error("bottom field pointer not used"); // R14

   property p_pixel_alpha;
      consume && (q.state == omx_pkg::ST_SHOW) && (q.mode == omx_pkg::MODE_PIXEL) && (ent[7:0] <= 8'h80)
         |-> factor == ent[7:0];
   endproperty
   a_pixel_alpha: assert property (p_pixel_alpha) else $error("pixel factor not from table"); // R17

   // Gain can push the factor past full, so it must saturate
   property p_prop_sat;
      consume && (q.state == omx_pkg::ST_SHOW) && (q.mode == omx_pkg::MODE_PROP) |-> factor <= 8'h80;
   endproperty
   a_prop_sat: assert property (p_prop_sat) else $error("proportional factor above full"); // R19 R24

   property p_load_cap;
      lut_we |-> chk_writes_q <= {1'b0, q.load_cnt};
   endproperty
   a_load_cap: assert property (p_load_cap) else $error("more palette words than asked"); // R6

   property p_top_first;
      start_ok |=> !q.field_bot && (q.addr == $past(q.top_ptr));
   endproperty
   a_top_first: assert property (p_top_first) else $error("region did not begin in top field"); // R10

   property p_out_pulse;
      consume |=> vid_out_valid;
   endproperty
   a_out_pulse: assert property (p_out_pulse) else $error("accepted pixel gave no output"); // R15

   property p_byte_step;
      consume && (q.state == omx_pkg::ST_SHOW) |=> q.byte_idx == $past(q.byte_idx) + 2'h1;
   endproperty
   a_byte_step: assert property (p_byte_step) else $error("pixel byte order broken"); // R23

   c_load_done:  cover property ((q.state == omx_pkg::ST_LOAD_WAIT) ##1 (q.state == omx_pkg::ST_SHOW));
   c_region_end: cover property ((q.state == omx_pkg::ST_SHOW) ##1 (q.state == omx_pkg::ST_IDLE));
   c_prop_mode:  cover property (consume && (q.state == omx_pkg::ST_SHOW) && (q.mode == omx_pkg::MODE_PROP));
   c_merged:     cover property (consume && q.merged && !q.field_bot && (q.pix_left == 22'h1));
   c_zero_gain:  cover property (consume && (q.mode == omx_pkg::MODE_PROP) && (q.gain == 9'h000));

endmodule
`default_nettype wire

/* test/omx_sdram_model.sv */
// SDRAM model serving palette and bitmap word reads to the mixer
`timescale 1ns/100ps
`default_nettype none
module omx_sdram_model #(
   parameter int RSP_WAIT = 2
) (
   input  wire logic                  core_clk,
   input  wire logic                  srst,
   input  wire omx_pkg::omx_mem_req_s mem_req,
   output logic                       mem_req_ready,
   output omx_pkg::omx_mem_rsp_s      mem_rsp
);
   logic [31:0] mem [0:255];
   logic        pend_q;
   logic        tog_q;
   logic [7:0]  idx_q;
   int          wait_q;

   // Accepts every other cycle, one request at a time, so the loader stalls
   assign mem_req_ready = tog_q & ~pend_q;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         tog_q         <= 1'h0;
         pend_q        <= 1'h0;
         idx_q         <= 8'h00;
         wait_q        <= 0;
         mem_rsp.valid <= 1'h0;
         mem_rsp.data  <= 32'h0000_0000;
      end else begin
         tog_q         <= ~tog_q;
         mem_rsp.valid <= 1'h0;
         // Released data bus toggles, showing the last word inverted every other cycle
         mem_rsp.data  <= ~mem_rsp.data;
         if (mem_req.valid && mem_req_ready) begin
            pend_q <= 1'h1;
            idx_q  <= mem_req.addr[9:2];
            wait_q <= RSP_WAIT;
         end else if (pend_q) begin
            if (wait_q == 0) begin
               mem_rsp.valid <= 1'h1;
               mem_rsp.data  <= mem[idx_q];
               pend_q        <= 1'h0;
            end else begin
               wait_q <= wait_q - 1;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* test/omx_mixer_tb_top.sv */
// Self-checking bench for the OSD palette loader and blender
`timescale 1ns/100ps
`default_nettype none
module omx_mixer_tb_top;
   logic                  core_clk = 1'h0;
   logic                  srst = 1'h1;
   logic                  psel = 1'h0;
   logic                  penable = 1'h0;
   logic                  pwrite = 1'h0;
   logic [7:0]            paddr = 8'h00;
   logic [31:0]           pwdata = 32'h0;
   logic [31:0]           prdata;
   logic                  pready;
   logic                  pslverr;
   omx_pkg::omx_mem_req_s mem_req;
   logic                  mem_req_ready;
   omx_pkg::omx_mem_rsp_s mem_rsp;
   logic                  vid_in_valid = 1'h0;
   omx_pkg::omx_rgb_s     vid_in_pix = 24'h0;
   logic                  vid_in_ready;
   logic                  vid_out_valid;
   omx_pkg::omx_rgb_s     vid_out_pix;
   int                    fails = 0;
   int                    n_checks = 0;
   int                    cyc = 0;
   logic [31:0]           lut [0:255];
   logic [31:0]           rd;
   logic                  err;

   always #25 core_clk = ~core_clk;

   omx_mixer u_dut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mem_req(mem_req), .mem_req_ready(mem_req_ready), .mem_rsp(mem_rsp), .vid_in_valid(vid_in_valid),
      .vid_in_pix(vid_in_pix), .vid_in_ready(vid_in_ready), .vid_out_valid(vid_out_valid),
      .vid_out_pix(vid_out_pix));

   omx_sdram_model u_mem (.core_clk(core_clk), .srst(srst), .mem_req(mem_req),
      .mem_req_ready(mem_req_ready), .mem_rsp(mem_rsp));

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails = fails + 1;
         print_verdict();
      end
   end

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_pix(input omx_pkg::omx_rgb_s got, input omx_pkg::omx_rgb_s exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: pixel got %h want %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'h1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      // Wait ends on the first cycle with pready high, which is tied high
      do begin
         @(posedge core_clk);
      end while (pready !== 1'h1);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge core_clk);
   endtask

   task automatic vid(input omx_pkg::omx_rgb_s v, input omx_pkg::omx_rgb_s exp);
      vid_in_valid <= 1'h1;
      vid_in_pix   <= v;
      do begin
         @(posedge core_clk);
      end while (vid_in_ready !== 1'h1);
      vid_in_valid <= 1'h0;
      #1;
      chk_word({31'h0, vid_out_valid}, 32'h1, "out valid");
      chk_pix(vid_out_pix, exp);
      @(posedge core_clk);
   endtask

   function automatic int fac(input logic [1:0] m, input logic [7:0] a, input logic [7:0] w, input logic [8:0] g);
      int x;
      int ac;
      ac = (a > 8'h80) ? 128 : int'(a);
      case (m)
         2'h0: x = ac;
         2'h1: x = (w > 8'h80) ? 128 : int'(w);
         2'h2: x = g[8] ? ac * g[7:0] : ((g[7:0] == 8'h00) ? 128 : ac * 128 / g[7:0]);
         default: x = 128;
      endcase
      return (x > 128) ? 128 : x;
   endfunction

   function automatic omx_pkg::omx_rgb_s blend(input logic [31:0] e, input omx_pkg::omx_rgb_s v, input int f);
      omx_pkg::omx_rgb_s o;
      o.r = 8'((e[31:24] * f + v.r * (128 - f)) >> 7);
      o.g = 8'((e[23:16] * f + v.g * (128 - f)) >> 7);
      o.b = 8'((e[15:8] * f + v.b * (128 - f)) >> 7);
      return o;
   endfunction

   task automatic load_cfg(input logic [31:0] ptr, input logic [7:0] cnt, input logic [7:0] st);
      apb(1'h1, 8'h04, ptr);
      apb(1'h1, 8'h08, {16'h0, st, cnt});
      for (int i = 0; i <= cnt; i++) lut[8'(st + i)] = u_mem.mem[ptr[9:2] + i];
   endtask

   task automatic run_region(input logic fresh, input logic [1:0] mode, input logic merged,
                             input logic [31:0] mix, input logic [31:0] bword);
      logic [31:0] w;
      logic [7:0]  ix;
      apb(1'h1, 8'h0C, mix);
      apb(1'h1, 8'h00, {27'h0, merged, mode, fresh, 1'h1});
      rd = 32'h0;
      // Wait for display, so palette load has finished first
      for (int k = 0; k < 40 && rd[2] !== 1'h1; k++) apb(1'h0, 8'h1C, 32'h0);
      for (int p = 0; p < 8; p++) begin
         w  = (p < 4) ? 32'h1312_1110 : bword;
         ix = w[8 * (p % 4) +: 8];
         vid(24'h204060, blend(lut[ix], 24'h204060, fac(mode, lut[ix][7:0], mix[7:0], mix[24:16])));
      end
      apb(1'h0, 8'h1C, 32'h0);
      chk_word(rd & 32'h0000_001F, 32'h0000_0018, "region done");
      apb(1'h1, 8'h1C, 32'h0000_0008);
      $display("test region mode %0d done", mode);
   endtask

   initial begin
      u_mem.mem[0]   = 32'hFF00_8040;
      u_mem.mem[1]   = 32'h10E0_30C0;
      u_mem.mem[2]   = 32'h8080_8000;
      u_mem.mem[3]   = 32'h00FF_FF20;
      u_mem.mem[16]  = 32'h4020_1080;
      // Beyond the one-colour load; must never reach the table
      u_mem.mem[17]  = 32'h0102_0350;
      u_mem.mem[64]  = 32'h1312_1110;
      u_mem.mem[65]  = 32'h1011_1213;
      u_mem.mem[128] = 32'h1110_1312;
      repeat (3) @(posedge core_clk);
      srst <= 1'h0;
      apb(1'h0, 8'h0C, 32'h0);
      chk_word(rd, 32'h0080_0080, "mix reset");
      apb(1'h0, 8'h20, 32'h0);
      chk_word({31'h0, err}, 32'h1, "unmapped");
      vid(24'h204060, 24'h204060);
      $display("test registers done");
      apb(1'h1, 8'h10, 32'h0000_0100);
      apb(1'h1, 8'h14, 32'h0000_0200);
      apb(1'h1, 8'h18, 32'h0000_0004);
      load_cfg(32'h0000_0000, 8'h03, 8'h10);
      run_region(1'h1, 2'h0, 1'h0, 32'h0080_0080, 32'h1110_1312);
      run_region(1'h0, 2'h1, 1'h0, 32'h0080_0030, 32'h1110_1312);
      run_region(1'h0, 2'h1, 1'h0, 32'h0080_00A0, 32'h1110_1312);
      run_region(1'h0, 2'h2, 1'h0, 32'h0102_0080, 32'h1110_1312);
      run_region(1'h0, 2'h2, 1'h0, 32'h00C0_0080, 32'h1110_1312);
      run_region(1'h0, 2'h2, 1'h0, 32'h0000_0080, 32'h1110_1312);
      run_region(1'h0, 2'h3, 1'h1, 32'h0080_0080, 32'h1011_1213);
      load_cfg(32'h0000_0040, 8'h00, 8'h12);
      run_region(1'h1, 2'h0, 1'h0, 32'h0080_0080, 32'h1110_1312);
      print_verdict();
   end
endmodule
`default_nettype wire
